// File: core/etp_timer.sv
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
module etp_timer (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic EXT_COUNT_PIN,
  output logic COMPARE_OUT_PIN_A,
  output logic COMPARE_OUT_PIN_B,
  output etp_pkg::etp_flags_type IRQ_REQ
);
  import etp_pkg::*;

  etp_state_type s_q;
  etp_state_type s_d;
  logic tick;
  logic match_a;
  logic match_b;
  logic force_a;
  logic force_b;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_cnt;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_mask;
  logic wr_flag;
  logic at_top;
  logic ovf_ev;
  logic [7:0] top_val;
  etp_kind_type kind;
  etp_flags_type set_ev;
  etp_flags_type clr_ev;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------

  // write strobes per register
  assign wr_ctrl_a = WR && ADDR == ADDR_CTRL_A;
  assign wr_ctrl_b = WR && ADDR == ADDR_CTRL_B;
  assign wr_cnt = WR && ADDR == ADDR_COUNT;
  assign wr_cmp_a = WR && ADDR == ADDR_CMP_A;
  assign wr_cmp_b = WR && ADDR == ADDR_CMP_B;
  assign wr_mask = WR && ADDR == ADDR_MASK;
  assign wr_flag = WR && ADDR == ADDR_FLAG;

  // force strobes act only outside the pwm modes
  assign force_a = wr_ctrl_b && WDATA[FORCE_A_BIT] && kind == ETP_NON_PWM;
  assign force_b = wr_ctrl_b && WDATA[FORCE_B_BIT] && kind == ETP_NON_PWM;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------

  // pwm family from the waveform mode field
  always_comb begin
    case (s_q.ctrl.wgm)
      WGM_PC_MAX: kind = ETP_PHASE;
      WGM_PC_CMPA: kind = ETP_PHASE;
      WGM_FAST_MAX: kind = ETP_FAST;
      WGM_FAST_CMPA: kind = ETP_FAST;
      default: kind = ETP_NON_PWM;
    endcase
  end

  // top of the count sequence
  always_comb begin
    case (s_q.ctrl.wgm)
      WGM_CTC: top_val = s_q.cmp_a_act;
      WGM_PC_CMPA: top_val = s_q.cmp_a_act;
      WGM_FAST_CMPA: top_val = s_q.cmp_a_act;
      default: top_val = CNT_MAX;
    endcase
  end

  assign at_top = s_q.cnt == top_val;

  // ----------------------------------------------------------------
  // tick source and compare units
  // ----------------------------------------------------------------

  // prescaler, pin synchroniser and edge choice
  etp_clock_select u_clock_select (
    .clk(CLK),
    .rst_n(RST_N),
    .cs(s_q.ctrl.cs),
    .ext_pin(EXT_COUNT_PIN),
    .tick(tick)
  );

  // unit a, independent of unit b
  etp_compare_unit u_compare_a (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick),
    .block(s_q.block),
    .count(s_q.cnt),
    .compare(s_q.cmp_a_act),
    .at_top(at_top),
    .com(s_q.ctrl.com_a),
    .kind(kind),
    .up(s_q.dir == ETP_UP),
    .force_hit(force_a),
    .match(match_a),
    .wave(COMPARE_OUT_PIN_A)
  );

  // unit b
  etp_compare_unit u_compare_b (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick),
    .block(s_q.block),
    .count(s_q.cnt),
    .compare(s_q.cmp_b_act),
    .at_top(at_top),
    .com(s_q.ctrl.com_b),
    .kind(kind),
    .up(s_q.dir == ETP_UP),
    .force_hit(force_b),
    .match(match_b),
    .wave(COMPARE_OUT_PIN_B)
  );

  // ----------------------------------------------------------------
  // counter, buffers, flags and bus
  // ----------------------------------------------------------------

  // overflow event for the current mode
  always_comb begin
    ovf_ev = 1'b0;
    if (tick && !wr_cnt) begin
      case (kind)
        ETP_NON_PWM: ovf_ev = s_q.cnt == CNT_MAX;
        ETP_FAST: ovf_ev = at_top;
        ETP_PHASE: ovf_ev = s_q.dir == ETP_DOWN && s_q.cnt == CNT_BOTTOM;
        default: ovf_ev = 1'b0;
      endcase
    end
  end

  // flag set and clear terms, set wins over a clear
  assign set_ev = {match_b, match_a, ovf_ev};
  assign clr_ev = wr_flag ? etp_flags_type'(WDATA[2:0]) : '0;

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    // control writes
    if (wr_ctrl_a) begin
      s_d.ctrl.com_a = WDATA[COM_A_LSB +: 2];
      s_d.ctrl.com_b = WDATA[COM_B_LSB +: 2];
      s_d.ctrl.wgm[1:0] = WDATA[WGM_LO_LSB +: 2];
    end
    if (wr_ctrl_b) begin
      s_d.ctrl.wgm[2] = WDATA[WGM_HI_BIT];
      s_d.ctrl.cs = WDATA[CS_LSB +: 3];
    end
    if (wr_cmp_a) begin
      s_d.cmp_a_buf = WDATA;
    end
    if (wr_cmp_b) begin
      s_d.cmp_b_buf = WDATA;
    end
    if (wr_mask) begin
      s_d.mask = etp_flags_type'(WDATA[2:0]);
    end
    // counting on the timer tick
    if (wr_cnt) begin
      s_d.cnt = WDATA;
      s_d.block = 1'b1;
    end else if (tick) begin
      s_d.block = 1'b0;
      case (kind)
        ETP_NON_PWM: begin
          if (s_q.ctrl.wgm == WGM_CTC && at_top) begin
            s_d.cnt = CNT_BOTTOM;
          end else begin
            s_d.cnt = 8'(s_q.cnt + 1'b1);
          end
        end
        ETP_FAST: begin
          if (at_top) begin
            s_d.cnt = CNT_BOTTOM;
            s_d.cmp_a_act = s_q.cmp_a_buf;
            s_d.cmp_b_act = s_q.cmp_b_buf;
          end else begin
            s_d.cnt = 8'(s_q.cnt + 1'b1);
          end
        end
        ETP_PHASE: begin
          if (s_q.dir == ETP_UP) begin
            if (at_top) begin
              s_d.dir = ETP_DOWN;
              s_d.cnt = 8'(s_q.cnt - 1'b1);
              s_d.cmp_a_act = s_q.cmp_a_buf;
              s_d.cmp_b_act = s_q.cmp_b_buf;
            end else begin
              s_d.cnt = 8'(s_q.cnt + 1'b1);
            end
          end else begin
            if (s_q.cnt == CNT_BOTTOM) begin
              s_d.dir = ETP_UP;
              s_d.cnt = 8'(s_q.cnt + 1'b1);
            end else begin
              s_d.cnt = 8'(s_q.cnt - 1'b1);
            end
          end
        end
        default: s_d.cnt = s_q.cnt;
      endcase
    end
    // outside pwm the buffers pass straight through
    if (kind == ETP_NON_PWM) begin
      s_d.cmp_a_act = s_d.cmp_a_buf;
      s_d.cmp_b_act = s_d.cmp_b_buf;
      s_d.dir = ETP_UP;
    end
    // sticky flags
    s_d.flags = (s_q.flags & ~clr_ev) | set_ev;
    // masked requests
    s_d.irq = s_d.flags & s_d.mask;
    // read data for one cycle only
    s_d.rdata = RESET_BYTE;
    if (RD) begin
      case (ADDR)
        ADDR_CTRL_A: s_d.rdata = {s_q.ctrl.com_a, s_q.ctrl.com_b,
                                  2'h0, s_q.ctrl.wgm[1:0]};
        ADDR_CTRL_B: s_d.rdata = {4'h0, s_q.ctrl.wgm[2], s_q.ctrl.cs};
        ADDR_COUNT: s_d.rdata = s_q.cnt;
        ADDR_CMP_A: s_d.rdata = s_q.cmp_a_buf;
        ADDR_CMP_B: s_d.rdata = s_q.cmp_b_buf;
        ADDR_MASK: s_d.rdata = {5'h00, s_q.mask};
        ADDR_FLAG: s_d.rdata = {5'h00, s_q.flags};
        default: s_d.rdata = RESET_BYTE;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign IRQ_REQ = s_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_stop_hold: assert property (
    (s_q.ctrl.cs == CS_STOP && !wr_cnt) |=> s_q.cnt == $past(s_q.cnt))
    else $error("counter moved with no clock source");
  a_normal_wrap: assert property (
    (tick && !wr_cnt && s_q.ctrl.wgm == WGM_NORMAL && s_q.cnt == CNT_MAX)
      |=> (s_q.cnt == CNT_BOTTOM && s_q.flags.ovf))
    else $error("normal wrap lost or overflow not flagged");
  a_match_flag_a: assert property (match_a |=> s_q.flags.cmpa)
    else $error("compare a match did not set its flag");
  a_match_flag_b: assert property (match_b |=> s_q.flags.cmpb)
    else $error("compare b match did not set its flag");
  a_ctc_reload: assert property (
    (tick && !wr_cnt && s_q.ctrl.wgm == WGM_CTC && s_q.cnt == s_q.cmp_a_act)
      |=> s_q.cnt == CNT_BOTTOM)
    else $error("counter not reloaded at compare a");
  a_irq_gate: assert property (s_q.irq == (s_q.flags & s_q.mask))
    else $error("request does not follow flag and mask");
  a_buffer_hold: assert property (
    (kind != ETP_NON_PWM && !(tick && at_top && !wr_cnt))
      |=> s_q.cmp_a_act == $past(s_q.cmp_a_act))
    else $error("active compare value changed away from top");
  a_phase_turn: assert property (
    (kind == ETP_PHASE && tick && !wr_cnt && s_q.dir == ETP_UP && at_top)
      |=> s_q.dir == ETP_DOWN)
    else $error("phase correct count did not turn at top");

  // bus reads and register writes
  a_rdata_idle: assert property (!RD |=> RDATA == RESET_BYTE)
    else $error("read data not back to rest after a read");
  a_count_write: assert property (
    wr_cnt |=> (s_q.cnt == $past(WDATA) && s_q.block))
    else $error("counter write not taken");
  a_cmp_write_a: assert property (
    wr_cmp_a |=> s_q.cmp_a_buf == $past(WDATA))
    else $error("compare a write not taken");
  a_cmp_write_b: assert property (
    wr_cmp_b |=> s_q.cmp_b_buf == $past(WDATA))
    else $error("compare b write not taken");
  a_write_block: assert property (
    wr_cnt |=> (!match_a && !match_b))
    else $error("match not blocked after a counter write");

  // flag life cycle
  a_force_no_flag: assert property (
    (force_a && !match_a && !s_q.flags.cmpa) |=> !s_q.flags.cmpa)
    else $error("forced action raised a flag");
  a_flag_clear: assert property (
    (clr_ev.ovf && !ovf_ev) |=> !s_q.flags.ovf)
    else $error("overflow flag not cleared");
  a_flag_sticky: assert property (
    (s_q.flags.cmpb && !clr_ev.cmpb) |=> s_q.flags.cmpb)
    else $error("compare b flag lost without a clear");

  // pwm turn points
  a_fast_wrap: assert property (
    (kind == ETP_FAST && tick && !wr_cnt && at_top)
      |=> (s_q.cnt == CNT_BOTTOM && s_q.flags.ovf))
    else $error("fast pwm did not wrap at top");
  a_phase_bottom: assert property (
    (kind == ETP_PHASE && tick && !wr_cnt && s_q.dir == ETP_DOWN
      && s_q.cnt == CNT_BOTTOM) |=> (s_q.dir == ETP_UP && s_q.flags.ovf))
    else $error("phase correct count did not turn at bottom");
endmodule

// File: inc/etp_pkg.sv
package etp_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_COUNT = 4'h2;
  localparam logic [3:0] ADDR_CMP_A = 4'h3;
  localparam logic [3:0] ADDR_CMP_B = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h5;
  localparam logic [3:0] ADDR_FLAG = 4'h6;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int COM_A_LSB = 6;
  localparam int COM_B_LSB = 4;
  localparam int WGM_LO_LSB = 0;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WGM_HI_BIT = 3;
  localparam int CS_LSB = 0;
  // ----------------------------------------------------------------
  // counter values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // clock source codes and prescaler masks
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] PRE_M8 = 10'h007;
  localparam logic [PRE_W-1:0] PRE_M64 = 10'h03F;
  localparam logic [PRE_W-1:0] PRE_M256 = 10'h0FF;
  localparam logic [PRE_W-1:0] PRE_M1024 = 10'h3FF;
  // ----------------------------------------------------------------
  // waveform modes and compare output actions
  // ----------------------------------------------------------------
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_CMPA = 3'h5;
  localparam logic [2:0] WGM_FAST_CMPA = 3'h7;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ETP_NON_PWM, ETP_FAST, ETP_PHASE} etp_kind_type;
  typedef enum logic {ETP_UP, ETP_DOWN} etp_dir_type;
  typedef struct packed {
    logic cmpb;
    logic cmpa;
    logic ovf;
  } etp_flags_type;
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] wgm;
    logic [2:0] cs;
  } etp_ctrl_type;
  typedef struct packed {
    etp_ctrl_type ctrl;
    logic [7:0] cnt;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_a_act;
    logic [7:0] cmp_b_act;
    etp_flags_type mask;
    etp_flags_type flags;
    etp_dir_type dir;
    logic block;
    logic [7:0] rdata;
    etp_flags_type irq;
  } etp_state_type;
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic s1;
    logic s2;
    logic s3;
  } etp_cs_state_type;
  typedef struct packed {
    logic wave;
  } etp_cu_state_type;
endpackage

// File: core/etp_clock_select.sv
`timescale 1ns/1ns
module etp_clock_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] cs,
  input wire logic ext_pin,
  output logic tick
);
  import etp_pkg::*;

  etp_cs_state_type s_q;
  etp_cs_state_type s_d;
  logic rise;
  logic fall;

  // free running prescaler and pin synchroniser
  always_comb begin
    s_d = s_q;
    s_d.pre = PRE_W'(s_q.pre + 1'b1);
    s_d.s1 = ext_pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // edges seen on the synchronised pin only
  assign rise = s_q.s2 && !s_q.s3;
  assign fall = !s_q.s2 && s_q.s3;

  // source and edge choice makes the timer tick
  always_comb begin
    case (cs)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (s_q.pre & PRE_M8) == PRE_M8;
      CS_DIV64: tick = (s_q.pre & PRE_M64) == PRE_M64;
      CS_DIV256: tick = (s_q.pre & PRE_M256) == PRE_M256;
      CS_DIV1024: tick = (s_q.pre & PRE_M1024) == PRE_M1024;
      CS_EXT_FALL: tick = fall;
      CS_EXT_RISE: tick = rise;
      default: tick = 1'b0;
    endcase
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_stop_no_tick: assert property (cs == CS_STOP |-> !tick)
    else $error("tick while no source selected");
  a_div8_spacing: assert property (
    (cs == CS_DIV8 && tick) |=> (!tick || cs != CS_DIV8) [*7])
    else $error("divide by 8 tick too early");
  a_ext_rise_tick: assert property (
    (cs == CS_EXT_RISE && $rose(s_q.s2)) |-> tick)
    else $error("rising pin edge gave no tick");
endmodule

// File: core/etp_compare_unit.sv
`timescale 1ns/1ns
module etp_compare_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic block,
  input wire logic [7:0] count,
  input wire logic [7:0] compare,
  input wire logic at_top,
  input wire logic [1:0] com,
  input wire etp_pkg::etp_kind_type kind,
  input wire logic up,
  input wire logic force_hit,
  output logic match,
  output logic wave
);
  import etp_pkg::*;

  etp_cu_state_type s_q;
  etp_cu_state_type s_d;

  // compare of active value against the counter on each tick, blocked after a counter write
  assign match = tick && !block && (count == compare);

  // waveform generator for one output
  always_comb begin
    s_d = s_q;
    if (force_hit && kind == ETP_NON_PWM) begin
      case (com)
        COM_TOGGLE: s_d.wave = !s_q.wave;
        COM_CLEAR: s_d.wave = 1'b0;
        COM_SET: s_d.wave = 1'b1;
        default: s_d.wave = s_q.wave;
      endcase
    end else if (tick && com != COM_NONE) begin
      case (kind)
        ETP_NON_PWM: begin
          if (match) begin
            case (com)
              COM_TOGGLE: s_d.wave = !s_q.wave;
              COM_CLEAR: s_d.wave = 1'b0;
              default: s_d.wave = 1'b1;
            endcase
          end
        end
        ETP_FAST: begin
          if (match && com != COM_TOGGLE) begin
            s_d.wave = (com == COM_SET);
          end else if (at_top && com != COM_TOGGLE) begin
            s_d.wave = (com == COM_CLEAR);
          end
        end
        ETP_PHASE: begin
          if (match && com != COM_TOGGLE) begin
            s_d.wave = (com == COM_SET) ? up : !up;
          end
        end
        default: s_d.wave = s_q.wave;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wave = s_q.wave;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_idle_action: assert property (com == COM_NONE |=> $stable(wave))
    else $error("output moved with no action selected");
  a_set_on_match: assert property (
    (kind == ETP_NON_PWM && match && !force_hit && com == COM_SET)
      |=> wave)
    else $error("set action not applied at match");
endmodule

// File: tb/etp_pin_partner.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// far side: count source on the pin, observer of waveform a
// ----------------------------------------------------------------
module etp_pin_partner (
  input wire logic clk,
  output logic ext_pin,
  input wire logic wave_a
);
  int high_a = 0;
  initial begin
    ext_pin = 1'b0;
  end
  // tally of cycles with output a high, pin seen as driven level
  always @(posedge clk) begin
    if (wave_a === 1'b1) begin
      high_a <= high_a + 1;
    end
  end
  // one level change, held past the input synchroniser
  task automatic level(input logic v);
    @(posedge clk);
    ext_pin <= v;
    repeat (4) @(posedge clk);
  endtask
  // whole pulses on the count pin
  task automatic pulses(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask
endmodule

// File: tb/tb_etp_timer.sv
`timescale 1ns/1ns
module tb_etp_timer;
  import etp_pkg::*;
  logic clk = 1'b0;
  logic rst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [7:0] rdata;
  logic ext_pin;
  logic pin_a;
  logic pin_b;
  etp_flags_type irq;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int h0;
  logic [7:0] v;
  int ratio [5] = '{1, 8, 64, 256, 1024};
  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  always #25 clk = ~clk;
  etp_timer dut (
    .CLK(clk),
    .RST_N(rst_n),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr_en),
    .RD(rd_en),
    .RDATA(rdata),
    .EXT_COUNT_PIN(ext_pin),
    .COMPARE_OUT_PIN_A(pin_a),
    .COMPARE_OUT_PIN_B(pin_b),
    .IRQ_REQ(irq)
  );
  etp_pin_partner partner (
    .clk(clk),
    .ext_pin(ext_pin),
    .wave_a(pin_a)
  );
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdv(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp,
                    input string what);
    logic [7:0] d;
    rdv(a, d);
    chk(d, exp, what);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      $display("[FAIL] t=%0t run did not finish", $time);
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, an unmapped place, full byte width, stopped counter
    wr(4'hF, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(4'(a), 8'h00, "reset value");
    end
    wr(ADDR_CMP_A, 8'hA5);
    wr(ADDR_CMP_B, 8'h5A);
    wr(ADDR_COUNT, 8'hFE);
    rd(ADDR_CMP_A, 8'hA5, "compare a");
    rd(ADDR_CMP_B, 8'h5A, "compare b");
    idle(20);
    rd(ADDR_COUNT, 8'hFE, "stopped counter");
    $display("test registers done");
    // pin source, edge choice, wrap and overflow request
    wr(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
    partner.level(1'b1);
    idle(6);
    rd(ADDR_COUNT, 8'hFF, "rising edge count");
    partner.level(1'b0);
    idle(6);
    rd(ADDR_COUNT, 8'hFF, "falling edge ignored");
    rd(ADDR_FLAG, 8'h00, "no flag before wrap");
    partner.pulses(1);
    idle(6);
    rd(ADDR_COUNT, 8'h00, "wrap to bottom");
    rd(ADDR_FLAG, 8'h01, "overflow flag");
    chk({5'h00, irq}, 8'h00, "masked request");
    wr(ADDR_MASK, 8'h01);
    idle(2);
    chk({5'h00, irq}, 8'h01, "overflow request");
    wr(ADDR_FLAG, 8'h01);
    idle(2);
    rd(ADDR_FLAG, 8'h00, "flag cleared");
    chk({5'h00, irq}, 8'h00, "request dropped");
    wr(ADDR_CTRL_B, {5'h00, CS_EXT_FALL});
    partner.level(1'b1);
    idle(6);
    rd(ADDR_COUNT, 8'h00, "rise ignored");
    partner.level(1'b0);
    idle(6);
    rd(ADDR_COUNT, 8'h01, "falling edge count");
    $display("test pin source done");
    // two compare units, each with its own flag
    wr(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
    wr(ADDR_CMP_A, 8'h03);
    wr(ADDR_CMP_B, 8'h05);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_MASK, 8'h06);
    partner.pulses(4);
    idle(6);
    rd(ADDR_FLAG, 8'h02, "match a only");
    chk({5'h00, irq}, 8'h02, "request a");
    partner.pulses(2);
    idle(6);
    rd(ADDR_FLAG, 8'h06, "match b too");
    chk({5'h00, irq}, 8'h06, "requests a b");
    $display("test compare done");
    // clear on compare, pin actions and late action change
    wr(ADDR_FLAG, 8'h07);
    wr(ADDR_CMP_A, 8'h02);
    wr(ADDR_CMP_B, 8'h01);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_A, 8'h42);
    partner.pulses(3);
    idle(6);
    rd(ADDR_COUNT, 8'h00, "reload at top");
    rd(ADDR_FLAG, 8'h06, "top is compare a");
    chk({6'h00, pin_b, pin_a}, 8'h01, "toggle a, b idle");
    wr(ADDR_CTRL_A, 8'h72);
    idle(4);
    chk({6'h00, pin_b, pin_a}, 8'h01, "no change before match");
    partner.pulses(2);
    idle(6);
    chk({6'h00, pin_b, pin_a}, 8'h03, "set b at match");
    $display("test waveform done");
    // phase correct duty, then a new duty through the buffer
    wr(ADDR_CMP_A, 8'h40);
    wr(ADDR_CTRL_A, 8'h81);
    wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
    idle(1100);
    h0 = partner.high_a;
    idle(510);
    chk(8'(partner.high_a - h0), 8'h80, "duty 0x40");
    wr(ADDR_CMP_A, 8'h20);
    idle(1100);
    h0 = partner.high_a;
    idle(510);
    chk(8'(partner.high_a - h0), 8'h40, "duty 0x20");
    // fast pwm: set at the wrap, clear at the match
    wr(ADDR_CTRL_A, 8'h83);
    idle(600);
    h0 = partner.high_a;
    idle(256);
    chk(8'(partner.high_a - h0), 8'h21, "fast duty 0x20");
    // fast pwm with compare a as top keeps the counter at or under it
    wr(ADDR_CTRL_B, 8'h09);
    idle(300);
    for (int i = 0; i < 6; i++) begin
      rdv(ADDR_COUNT, v);
      chk({7'h00, v <= 8'h20}, 8'h01, "counter within top");
    end
    $display("test pwm done");
    // prescaler codes: about eight ticks over eight periods each
    wr(ADDR_CTRL_A, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTRL_B, 8'h00);
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CTRL_B, {5'h00, 3'(i + 1)});
      idle(8 * ratio[i] - 2);
      wr(ADDR_CTRL_B, 8'h00);
      rdv(ADDR_COUNT, v);
      chk({7'h00, v >= 8'h07 && v <= 8'h09}, 8'h01, "ratio");
    end
    $display("test prescaler done");
    // forced action moves the pin at once and raises no flag
    wr(ADDR_FLAG, 8'h07);
    wr(ADDR_CTRL_A, 8'h40);
    v = {7'h00, pin_a};
    wr(ADDR_CTRL_B, 8'h80);
    idle(1);
    chk({7'h00, pin_a}, v ^ 8'h01, "forced toggle");
    rd(ADDR_FLAG, 8'h00, "force gives no flag");
    // reset in mid run brings registers and pins back to rest
    idle(1);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rd(ADDR_CTRL_A, 8'h00, "control after reset");
    rd(ADDR_CMP_A, 8'h00, "compare after reset");
    rd(ADDR_MASK, 8'h00, "mask after reset");
    chk({6'h00, pin_b, pin_a}, 8'h00, "pins after reset");
    chk({5'h00, irq}, 8'h00, "request after reset");
    $display("test force and reset done");
    end_sim();
  end
endmodule
